// ===== awt_pkg.sv
// Purpose: constants for the auto-reload / watchdog 8-bit timer
// Assumes: single clock, byte-wide software access strobes
// Notes:
// Contract
// - counter write also loads reload register
// - run bit 3 starts/halts auto-reload counting
// - counter increments per selected count tick
// - auto-reload overflow raises irq and reloads
// - bit 7 write enters watchdog mode
// - watchdog mode left only by reset
// - first code-3 write starts, counter kept
// - alternate C then 3 writes reload counter
// - only low nibble of code decoded
// - bit 6 shows next expected code
// - watchdog overflow requests system reset
// - watchdog reset uses vector address 0004
// - timeout is divider times (256 minus reload)
// - overflow flag set only in auto-reload
// - overflow irq to cpu gated by enable flag, request output ungated
// - two priority bits give three levels
// - clock select divides time base 8..4096
// - watchdog mode ignores timeout-changing writes
// - bit 5 reads one while watchdog counts
// - reload register read-only in watchdog mode
`default_nettype none
package awt_pkg;
    localparam int        AWT_W          = 8;
    localparam int        AWT_PRE_W      = 12;
    localparam int        AWT_CSEL_LO    = 0;
    localparam int        AWT_CSEL_HI    = 2;
    localparam int        AWT_RUN_BIT    = 3;
    localparam int        AWT_ONE_BIT    = 4;
    localparam int        AWT_ACTIVE_BIT = 5;
    localparam int        AWT_NEXT_BIT   = 6;
    localparam int        AWT_MODE_BIT   = 7;
    localparam logic [7:0] AWT_CTL_RST   = 8'h10;
    localparam logic [7:0] AWT_CNT_RST   = 8'h00;
    localparam logic [7:0] AWT_CNT_MAX   = 8'hFF;
    localparam logic [3:0] AWT_CODE_3    = 4'h3;
    localparam logic [3:0] AWT_CODE_C    = 4'hC;
    localparam logic [15:0] AWT_WDT_VEC  = 16'h0004;
    localparam logic [1:0] AWT_PRI_MAX   = 2'h2;
endpackage
`default_nettype wire

// ===== awt_prescaler.sv
// Purpose: count-clock divider on the time-base tick
// Assumes: time_base_tick is a one-cycle enable on ref_clk
// Notes: counter held clear while disabled so the first period is full
`timescale 1ns/1ps
`default_nettype none
module awt_prescaler
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       time_base_tick,
    input  wire logic [2:0] clock_select,
    output logic            count_tick
);
    import awt_pkg::*;

    logic [AWT_PRE_W-1:0] pre_r;
    logic [AWT_PRE_W-1:0] mask;

    // low-bit mask: 8,16,32,64,128,256,1024,4096
    function automatic logic [AWT_PRE_W-1:0] div_mask(input logic [2:0] sel);
        logic [AWT_PRE_W-1:0] m;
        m = 12'h000;
        case (sel)
            3'h0:    m = 12'h007;
            3'h1:    m = 12'h00F;
            3'h2:    m = 12'h01F;
            3'h3:    m = 12'h03F;
            3'h4:    m = 12'h07F;
            3'h5:    m = 12'h0FF;
            3'h6:    m = 12'h3FF;
            default: m = 12'hFFF;
        endcase
        return m;
    endfunction

    assign mask = div_mask(clock_select);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_r <= 12'h000;
        else if (!enable)
            pre_r <= 12'h000;
        else if (time_base_tick)
            pre_r <= pre_r + 12'h001;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_tick <= 1'b0;
        else
            count_tick <= enable && time_base_tick && ((pre_r & mask) == mask);
    end
endmodule
`default_nettype wire

// ===== awt_timer.sv
// Purpose: 8-bit auto-reload timer with one-way watchdog mode
// Assumes: software strobes are one-cycle pulses on ref_clk
// Notes: read values lag the stored state by one cycle
`timescale 1ns/1ps
`default_nettype none
module awt_timer
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        time_base_tick,
    input  wire logic        counter_wr,
    input  wire logic        reload_wr,
    input  wire logic        control_wr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        irq_flag_clr,
    input  wire logic        overflow_irq_enable,
    input  wire logic        overflow_priority_low,
    input  wire logic        overflow_priority_high,
    output logic [7:0]       up_counter8,
    output logic [7:0]       reload_value_reg,
    output logic [7:0]       timer_control_reg,
    output logic             overflow_irq_request,
    output logic             irq_to_cpu,
    output logic [1:0]       irq_level,
    output logic             wdt_reset_req,
    output logic [15:0]      wdt_vector_addr
);
    import awt_pkg::*;

    logic [7:0] cnt_r;
    logic [7:0] rld_r;
    logic [2:0] csel_r;
    logic       run_r;
    logic       mode_r;
    logic       active_r;
    logic       next_c_r;
    logic       flag_r;
    logic       count_tick;
    logic       counting;
    logic       overflow;
    logic [3:0] code;
    logic       code_ok;
    logic       refresh;
    logic       activate;

    function automatic logic [1:0] pri_level(input logic hi, input logic lo);
        logic [1:0] p;
        p = {hi, lo};
        if (p > AWT_PRI_MAX)
            p = AWT_PRI_MAX;
        return p;
    endfunction

    assign counting = mode_r ? active_r : run_r;
    assign overflow = counting && count_tick && (cnt_r == AWT_CNT_MAX);
    assign code     = wr_data[3:0];
    assign code_ok  = next_c_r ? (code == AWT_CODE_C) : (code == AWT_CODE_3);
    assign activate = mode_r && counter_wr && !active_r && (code == AWT_CODE_3);
    assign refresh  = mode_r && counter_wr && active_r && code_ok;

    awt_prescaler u_pre
    (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .enable         (counting),
        .time_base_tick (time_base_tick),
        .clock_select   (csel_r),
        .count_tick     (count_tick)
    );

    // control register fields
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            csel_r <= 3'h0;
            run_r  <= 1'b0;
            mode_r <= 1'b0;
        end
        else if (control_wr)
        begin
            run_r <= wr_data[AWT_RUN_BIT];
            if (!mode_r)
            begin
                csel_r <= wr_data[AWT_CSEL_HI:AWT_CSEL_LO];
                mode_r <= wr_data[AWT_MODE_BIT];
            end
        end
    end

    // reload register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rld_r <= AWT_CNT_RST;
        else if (!mode_r && (counter_wr || reload_wr))
            rld_r <= wr_data;
    end

    // counter: timeout = tick period x (256 - reload)
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= AWT_CNT_RST;
        else if (!mode_r && counter_wr)
            cnt_r <= wr_data;
        else if (refresh)
            cnt_r <= rld_r;
        else if (overflow && !mode_r)
            cnt_r <= rld_r;
        else if (counting && count_tick)
            cnt_r <= cnt_r + 8'h01;
    end

    // watchdog start and code sequencing
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_r <= 1'b0;
            next_c_r <= 1'b0;
        end
        else if (activate)
        begin
            active_r <= 1'b1;
            next_c_r <= 1'b1;
        end
        else if (refresh)
            next_c_r <= !next_c_r;
    end

    // overflow interrupt flag, set beats clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= 1'b0;
        else if (overflow && !mode_r)
            flag_r <= 1'b1;
        else if (irq_flag_clr)
            flag_r <= 1'b0;
    end

    // watchdog reset request held until system reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wdt_reset_req <= 1'b0;
        else if (overflow && mode_r && !refresh)
            wdt_reset_req <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wdt_vector_addr <= AWT_WDT_VEC;
        else
            wdt_vector_addr <= AWT_WDT_VEC;
    end

    // interrupt outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_irq_request <= 1'b0;
            irq_to_cpu           <= 1'b0;
            irq_level            <= 2'h0;
        end
        else
        begin
            overflow_irq_request <= flag_r;
            irq_to_cpu           <= flag_r && overflow_irq_enable;
            irq_level            <= pri_level(overflow_priority_high,
                                              overflow_priority_low);
        end
    end

    // software-visible read values
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            up_counter8       <= AWT_CNT_RST;
            reload_value_reg  <= AWT_CNT_RST;
            timer_control_reg <= AWT_CTL_RST;
        end
        else
        begin
            up_counter8       <= cnt_r;
            reload_value_reg  <= rld_r;
            timer_control_reg <= {mode_r, next_c_r, active_r, 1'b1, run_r, csel_r};
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    reload_copy_a: assert property (
        (!mode_r && counter_wr) |=> (rld_r == $past(wr_data)) && (cnt_r == $past(wr_data)))
        else $error("counter write did not copy to reload");

    halt_hold_a: assert property (
        (!mode_r && !run_r && !counter_wr) |=> (cnt_r == $past(cnt_r)))
        else $error("halted counter moved");

    count_step_a: assert property (
        (counting && count_tick && !overflow && !counter_wr)
            |=> (cnt_r == $past(cnt_r) + 8'h01))
        else $error("counter did not step on tick");

    auto_reload_a: assert property (
        (!mode_r && overflow && !counter_wr) |=> (cnt_r == $past(rld_r)) && flag_r
            ##1 overflow_irq_request)
        else $error("overflow did not reload and flag");

    mode_sticky_a: assert property (
        mode_r |=> mode_r)
        else $error("watchdog mode was left");

    activate_keep_a: assert property (
        activate |=> active_r && next_c_r && $stable(cnt_r) ##1 timer_control_reg[5])
        else $error("activation changed counter or did not start");

    refresh_c_a: assert property (
        (refresh && next_c_r) |=> (cnt_r == $past(rld_r)) && !next_c_r)
        else $error("code C refresh did not reload");

    bad_code_a: assert property (
        (mode_r && active_r && counter_wr && !code_ok && !count_tick)
            |=> $stable(cnt_r) && $stable(next_c_r))
        else $error("wrong code altered state");

    wdt_reset_a: assert property (
        (mode_r && overflow && !refresh) |=> wdt_reset_req [*2])
        else $error("watchdog overflow did not request reset");

    cfg_locked_a: assert property (
        mode_r |=> $stable(rld_r) && $stable(csel_r))
        else $error("timeout setting changed in watchdog mode");

    wdt_no_irq_a: assert property (
        (mode_r && !flag_r) |=> !flag_r)
        else $error("overflow flag set in watchdog mode");

    irq_gate_a: assert property (
        (!overflow_irq_enable) |=> !irq_to_cpu)
        else $error("interrupt passed while disabled");

    reload_lock_a: assert property (
        (mode_r && reload_wr) |=> $stable(rld_r))
        else $error("reload register written in watchdog mode");

    run_store_a: assert property (
        control_wr |=> ({4'h0, run_r, 3'h0} == ($past(wr_data) & 8'h08)))
        else $error("run bit not stored");

    mode_enter_a: assert property (
        (control_wr && !mode_r) |=> ({mode_r, 4'h0, csel_r} == ($past(wr_data) & 8'h87)))
        else $error("mode or clock select not taken");

    csel_lock_a: assert property (
        (mode_r && control_wr) |=> $stable(csel_r) && mode_r)
        else $error("clock select changed in watchdog mode");

    counter_lock_a: assert property (
        (mode_r && counter_wr && !refresh && !count_tick) |=> $stable(cnt_r))
        else $error("counter written in watchdog mode");

    refresh_3_a: assert property (
        (refresh && !next_c_r) |=> (cnt_r == $past(rld_r)) && next_c_r)
        else $error("code 3 refresh did not reload");

    nibble_only_a: assert property (
        (mode_r && active_r && counter_wr
            && (wr_data[3:0] == (next_c_r ? AWT_CODE_C : AWT_CODE_3)))
            |=> (next_c_r != $past(next_c_r)))
        else $error("code with any upper nibble not accepted");

    next_read_a: assert property (
        1'b1 |=> (timer_control_reg[AWT_NEXT_BIT] == $past(next_c_r)))
        else $error("next code bit not shown");

    active_read_a: assert property (
        1'b1 |=> (timer_control_reg[AWT_ACTIVE_BIT] == $past(active_r)))
        else $error("watchdog counting bit not shown");

    active_sticky_a: assert property (
        active_r |=> active_r)
        else $error("watchdog counting stopped");

    idle_hold_a: assert property (
        (mode_r && !active_r) |=> $stable(cnt_r))
        else $error("counter moved before activation");

    set_wins_a: assert property (
        (overflow && !mode_r && irq_flag_clr) |=> flag_r)
        else $error("clear beat overflow set");

    flag_clear_a: assert property (
        (irq_flag_clr && !overflow) |=> !flag_r)
        else $error("overflow flag not cleared");

    irq_pass_a: assert property (
        (flag_r && overflow_irq_enable) |=> irq_to_cpu)
        else $error("enabled interrupt not passed");

    level_low_a: assert property (
        (!overflow_priority_high) |=> (irq_level == {1'b0, $past(overflow_priority_low)}))
        else $error("priority level wrong");

    level_clamp_a: assert property (
        irq_level != 2'h3)
        else $error("priority level out of range");

    tick_spacing_a: assert property (
        count_tick |=> !count_tick [*7])
        else $error("count ticks closer than smallest divisor");

    req_hold_a: assert property (
        wdt_reset_req |=> wdt_reset_req)
        else $error("reset request dropped");

    req_auto_a: assert property (
        (!mode_r && !wdt_reset_req) |=> !wdt_reset_req)
        else $error("reset request in auto-reload mode");

    vector_fixed_a: assert property (
        wdt_vector_addr == AWT_WDT_VEC)
        else $error("watchdog vector wrong");

    wdt_wrap_a: assert property (
        (mode_r && overflow && !refresh) |=> (cnt_r == AWT_CNT_RST))
        else $error("watchdog overflow did not wrap");

    irq_copy_a: assert property (
        1'b1 |=> (overflow_irq_request == $past(flag_r)))
        else $error("request output does not follow flag");

    count_read_a: assert property (
        1'b1 |=> (up_counter8 == $past(cnt_r)))
        else $error("counter read value wrong");

    reload_read_a: assert property (
        1'b1 |=> (reload_value_reg == $past(rld_r)))
        else $error("reload read value wrong");
endmodule
`default_nettype wire

// ===== awt_timer_tb.sv
// Purpose: self-checking bench for the auto-reload / watchdog timer
// Assumes: inputs driven at rising edges, outputs sampled at falling edges
// Notes: time base tick held high, so divisors count ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module awt_timer_tb;
    import awt_pkg::*;
    logic        ref_clk;
    logic        rst_n;
    logic        time_base_tick;
    logic        counter_wr;
    logic        reload_wr;
    logic        control_wr;
    logic [7:0]  wr_data;
    logic        irq_flag_clr;
    logic        irq_en;
    logic        pri_lo;
    logic        pri_hi;
    logic [7:0]  cnt;
    logic [7:0]  rld;
    logic [7:0]  ctl;
    logic        irq_req;
    logic        irq_cpu;
    logic [1:0]  lvl;
    logic        wdt_req;
    logic [15:0] vec;
    int          n_fail;
    int          samples_checked;

    awt_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .time_base_tick(time_base_tick),
        .counter_wr(counter_wr), .reload_wr(reload_wr), .control_wr(control_wr),
        .wr_data(wr_data), .irq_flag_clr(irq_flag_clr), .overflow_irq_enable(irq_en),
        .overflow_priority_low(pri_lo), .overflow_priority_high(pri_hi),
        .up_counter8(cnt), .reload_value_reg(rld), .timer_control_reg(ctl),
        .overflow_irq_request(irq_req), .irq_to_cpu(irq_cpu), .irq_level(lvl),
        .wdt_reset_req(wdt_req), .wdt_vector_addr(vec));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sel: 0 counter, 1 reload, 2 control; returns once read ports show it
    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge ref_clk);
        wr_data <= d;
        counter_wr <= (sel == 0);
        reload_wr <= (sel == 1);
        control_wr <= (sel == 2);
        @(posedge ref_clk);
        counter_wr <= 1'b0;
        reload_wr <= 1'b0;
        control_wr <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic wait_chg(output int n);
        logic [7:0] old;
        old = cnt;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end while (cnt === old && n < 10000);
        if (n >= 10000)
        begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic t_auto();
        int i;
        logic [7:0] c0;
        wr(0, 8'hFE);
        chk(cnt, 8'hFE);
        chk(rld, 8'hFE);
        wr(1, 8'h55);
        chk(rld, 8'h55);
        wr(2, 8'h08);
        for (i = 0; i < 300 && irq_req !== 1'b1; i++)
            @(negedge ref_clk);
        if (irq_req !== 1'b1)
        begin
            n_fail++;
            test_done();
        end
        chk(cnt, 8'h55);
        chk(irq_req, 1'b1);
        repeat (2) @(negedge ref_clk);
        chk(irq_cpu, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            pri_lo <= i[0];
            pri_hi <= i[1];
            repeat (3) @(negedge ref_clk);
            chk(lvl, (i == 3) ? 2'h2 : i[1:0]);
        end
        @(posedge ref_clk);
        irq_en <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(irq_cpu, 1'b0);
        chk(irq_req, 1'b1);
        @(posedge ref_clk);
        irq_flag_clr <= 1'b1;
        @(posedge ref_clk);
        irq_flag_clr <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(irq_cpu, 1'b0);
        chk(irq_req, 1'b0);
        wr(2, 8'h00);
        c0 = cnt;
        repeat (40) @(negedge ref_clk);
        chk(cnt, c0);
    endtask

    task automatic t_csel();
        int n;
        int d;
        for (int k = 0; k < 8; k++)
        begin
            d = (k < 6) ? (8 << k) : ((k == 6) ? 1024 : 4096);
            wr(2, 8'h08 | k[7:0]);
            wait_chg(n);
            wait_chg(n);
            chk(n[15:0], d[15:0]);
            wr(2, 8'h00);
        end
    endtask

    task automatic t_wdt();
        int n;
        logic [7:0] c0;
        wr(0, 8'h20);
        wr(1, 8'hF0);
        wr(2, 8'h80);
        chk(ctl, 8'h90);
        wr(1, 8'h11);
        chk(rld, 8'hF0);
        wr(2, 8'h0D);
        chk(ctl, 8'h98);
        c0 = cnt;
        wr(0, 8'hA3);
        chk(cnt, c0);
        chk(ctl[6:5], 2'h3);
        wr(0, 8'h73);
        chk(ctl[6], 1'b1);
        chk(cnt, c0);
        wr(0, 8'hFC);
        chk(cnt, 8'hF0);
        chk(ctl[6], 1'b0);
        wr(0, 8'h53);
        chk(cnt, 8'hF0);
        chk(ctl[6], 1'b1);
        n = 0;
        while (wdt_req !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400)
        begin
            n_fail++;
            test_done();
        end
        chk(n >= 110 && n <= 135, 1'b1);
        chk(vec, AWT_WDT_VEC);
        chk(irq_req, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(ctl, AWT_CTL_RST);
        chk(wdt_req, 1'b0);
    endtask

    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        time_base_tick = 1'b0;
        counter_wr = 1'b0;
        reload_wr = 1'b0;
        control_wr = 1'b0;
        wr_data = 8'h00;
        irq_flag_clr = 1'b0;
        irq_en = 1'b1;
        pri_lo = 1'b0;
        pri_hi = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        time_base_tick <= 1'b1;
        @(negedge ref_clk);
        chk(ctl, AWT_CTL_RST);
        chk(vec, AWT_WDT_VEC);
        t_auto();
        t_csel();
        t_wdt();
        test_done();
    end
endmodule
`default_nettype wire
